// [core/serial_channel.sv]
/*
 one serial channel: clocked shift-register i/o mode and 7/8/9-bit uart
 modes, apb register file, sticky interrupt status with mask.
 assumes pins and the external shift clock are asynchronous to pclk.
*/
`timescale 1ns/1ps
module serial_channel
(
   input wire logic pclk,
   input wire logic presetn,
   input serial_channel_pkg::apb_req_type apb_req,
   output serial_channel_pkg::apb_rsp_type apb_rsp,
   input serial_channel_pkg::pin_in_type pins_in,
   output serial_channel_pkg::pin_out_type pins_out,
   output logic irq
);
   import serial_channel_pkg::*;

   // ======================================================
   // state
   typedef struct packed
   {
      logic [1:0] sync_sclk;
      logic [1:0] sync_rxd;
      logic sclk_prev;
      logic rxd_prev;
      mode_type mode;
      logic receive_enable;
      logic wu;
      logic tb8;
      logic ext_clk;
      logic odrain;
      logic pe;
      logic even;
      logic rb8;
      logic perr;
      logic ferr;
      logic [1:0] status;
      logic [1:0] mask;
      logic [15:0] div;
      logic tx_pend;
      logic tx_busy;
      logic tx_half;
      logic [3:0] tx_cnt;
      logic [3:0] tx_len;
      logic [10:0] tx_shift;
      logic rx_busy;
      logic rx_half;
      logic [3:0] rx_cnt;
      logic [10:0] rx_shift;
      logic [7:0] rx_buf;
      logic io_busy;
      logic io_tx;
      logic io_rx;
      logic sclk_out;
      logic txd;
   } state_type;

   state_type s_q;
   state_type s_d;
   logic tx_tick;
   logic rx_tick;

   // ======================================================
   // frame helpers
   function automatic logic [3:0] data_bits(input mode_type m);
      data_bits = (m == MODE_UART7) ? 4'h7 : 4'h8;
   endfunction

   function automatic logic has_extra(input mode_type m, input logic pe);
      has_extra = (m == MODE_UART9) || pe;
   endfunction

   // start + data + optional extra + stop
   function automatic logic [3:0] frame_len(input mode_type m, input logic pe);
      frame_len = data_bits(m) + 4'h2 + {3'h0, has_extra(m, pe)};
   endfunction

   function automatic logic par_bit(input logic [7:0] d, input logic even);
      par_bit = even ? ^d : ~^d;
   endfunction

   function automatic logic [10:0] frame_build(input mode_type m, input logic pe, input logic even,
      input logic tb8, input logic [7:0] wd);
      logic [7:0] d;
      logic x;
      logic [10:0] f;
      d = (m == MODE_UART7) ? {1'b0, wd[6:0]} : wd;
      x = (m == MODE_UART9) ? tb8 : par_bit(d, even);
      f = 11'h7ff;
      f[0] = 1'b0;
      if (m == MODE_UART7)
      begin
         f[7:1] = d[6:0];
         if (pe)
         begin
            f[8] = x;
         end
      end
      else
      begin
         f[8:1] = d;
         if (has_extra(m, pe))
         begin
            f[9] = x;
         end
      end
      frame_build = f;
   endfunction

   // ======================================================
   // bit timers
   bit_timer tx_timer
   (
      .pclk(pclk),
      .presetn(presetn),
      .restart(!(s_q.tx_busy || (s_q.io_busy && !s_q.ext_clk))),
      .div(s_q.div),
      .tick(tx_tick)
   );

   bit_timer rx_timer
   (
      .pclk(pclk),
      .presetn(presetn),
      .restart(!s_q.rx_busy),
      .div(s_q.div),
      .tick(rx_tick)
   );

   // ======================================================
   // bus decode
   logic acc;
   logic wr;
   logic rd;
   logic hit;
   logic [31:0] rdata;

   assign acc = apb_req.psel && apb_req.penable;
   assign wr = acc && apb_req.pwrite;
   assign rd = acc && !apb_req.pwrite;

   always_comb
   begin
      hit = 1'b1;
      rdata = 32'h0000_0000;
      unique case (apb_req.paddr)
         BUF_OFS: rdata = {24'h00_0000, s_q.rx_buf};
         MODE_OFS: rdata = {25'h0, s_q.odrain, s_q.ext_clk, s_q.tb8, s_q.wu, s_q.receive_enable, s_q.mode};
         CTRL_OFS: rdata = {27'h0, s_q.ferr, s_q.perr, s_q.rb8, s_q.even, s_q.pe};
         STAT_OFS: rdata = {30'h0, s_q.status};
         MASK_OFS: rdata = {30'h0, s_q.mask};
         DIV_OFS: rdata = {16'h0000, s_q.div};
         default: hit = 1'b0;
      endcase
   end

   assign apb_rsp.pready = 1'b1;
   assign apb_rsp.pslverr = acc && !hit;
   assign apb_rsp.prdata = rd ? rdata : 32'h0000_0000;

   // ======================================================
   // synchronised pin events
   logic sclk_rise;
   logic sclk_fall;
   logic rxd_fall;
   logic sin;
   logic io_mode;
   logic rx_ready;
   logic fall_ev;
   logic rise_ev;

   assign sin = s_q.sync_rxd[1];
   assign sclk_rise = s_q.sync_sclk[1] && !s_q.sclk_prev;
   assign sclk_fall = !s_q.sync_sclk[1] && s_q.sclk_prev;
   assign rxd_fall = !sin && s_q.rxd_prev;
   assign io_mode = (s_q.mode == MODE_IO);
   assign rx_ready = s_q.receive_enable && !s_q.status[STAT_RX_BIT];

   // internal clock idles high: a tick with it high is a falling edge
   always_comb
   begin
      if (s_q.ext_clk)
      begin
         fall_ev = s_q.io_busy && sclk_fall;
         rise_ev = s_q.io_busy && sclk_rise;
      end
      else
      begin
         fall_ev = s_q.io_busy && tx_tick && s_q.sclk_out;
         rise_ev = s_q.io_busy && tx_tick && !s_q.sclk_out;
      end
   end

   // ======================================================
   // next state
   logic [10:0] rx_new;
   logic [10:0] rx_frame;
   logic [3:0] rlen;
   logic [7:0] rdat;
   logic rext;
   logic deliver;

   always_comb
   begin
      s_d = s_q;
      rx_new = {sin, s_q.rx_shift[10:1]};
      rlen = frame_len(s_q.mode, s_q.pe);
      rx_frame = rx_new >> (4'hb - rlen);
      rdat = (s_q.mode == MODE_UART7) ? {1'b0, rx_frame[7:1]} : rx_frame[8:1];
      rext = (s_q.mode == MODE_UART7) ? rx_frame[8] : rx_frame[9];
      deliver = !(s_q.mode == MODE_UART9 && s_q.wu && !rext);

      // first stage feeds only the second
      s_d.sync_sclk = {s_q.sync_sclk[0], pins_in.shift_clock_pin};
      s_d.sync_rxd = {s_q.sync_rxd[0], pins_in.serial_in_pin};
      s_d.sclk_prev = s_q.sync_sclk[1];
      s_d.rxd_prev = s_q.sync_rxd[1];

      // register writes; flag clears come first so hardware sets win
      if (wr)
      begin
         unique case (apb_req.paddr)
            BUF_OFS:
            begin
               s_d.tx_pend = 1'b1;
               s_d.tx_len = io_mode ? IO_BITS : frame_len(s_q.mode, s_q.pe);
               s_d.tx_shift = io_mode ? {3'h7, apb_req.pwdata[7:0]}
                  : frame_build(s_q.mode, s_q.pe, s_q.even, s_q.tb8, apb_req.pwdata[7:0]);
            end
            MODE_OFS:
            begin
               s_d.mode = mode_type'(apb_req.pwdata[MODE_SM_LO +: 2]);
               s_d.receive_enable = apb_req.pwdata[MODE_RXE_BIT];
               s_d.wu = apb_req.pwdata[MODE_WU_BIT];
               s_d.tb8 = apb_req.pwdata[MODE_TB8_BIT];
               s_d.ext_clk = apb_req.pwdata[MODE_EXTCLK_BIT];
               s_d.odrain = apb_req.pwdata[MODE_ODRAIN_BIT];
            end
            CTRL_OFS:
            begin
               s_d.pe = apb_req.pwdata[CTRL_PE_BIT];
               s_d.even = apb_req.pwdata[CTRL_EVEN_BIT];
            end
            STAT_OFS: s_d.status = s_q.status & ~apb_req.pwdata[1:0];
            MASK_OFS: s_d.mask = apb_req.pwdata[1:0];
            DIV_OFS: s_d.div = apb_req.pwdata[15:0];
            default: ;
         endcase
      end
      // reading the received byte frees the receiver
      if (rd && apb_req.paddr == BUF_OFS)
      begin
         s_d.status[STAT_RX_BIT] = 1'b0;
      end

      // ===================================================
      // i/o interface mode
      if (io_mode && !s_q.io_busy && (s_q.tx_pend || rx_ready))
      begin
         s_d.io_busy = 1'b1;
         s_d.io_tx = s_q.tx_pend;
         s_d.io_rx = rx_ready;
         s_d.tx_pend = 1'b0;
         s_d.tx_cnt = 4'h0;
      end
      if (s_q.io_busy && !s_q.ext_clk && tx_tick)
      begin
         s_d.sclk_out = !s_q.sclk_out;
      end
      if (fall_ev && s_q.io_tx)
      begin
         s_d.txd = s_q.tx_shift[0];
      end
      if (rise_ev)
      begin
         s_d.rx_shift = rx_new;
         s_d.tx_shift = {1'b1, s_q.tx_shift[10:1]};
         s_d.tx_cnt = s_q.tx_cnt + 4'h1;
         if (s_q.tx_cnt == IO_BITS - 4'h1)
         begin
            s_d.io_busy = 1'b0;
            if (s_q.io_tx)
            begin
               s_d.status[STAT_TX_BIT] = 1'b1;
            end
            if (s_q.io_rx)
            begin
               s_d.rx_buf = rx_new[10:3];
               s_d.status[STAT_RX_BIT] = 1'b1;
            end
         end
      end

      // ===================================================
      // uart transmitter: two ticks per bit
      if (!io_mode && !s_q.tx_busy && s_q.tx_pend)
      begin
         s_d.tx_busy = 1'b1;
         s_d.tx_pend = 1'b0;
         s_d.tx_cnt = 4'h0;
         s_d.tx_half = 1'b0;
      end
      if (s_q.tx_busy && tx_tick)
      begin
         s_d.tx_half = !s_q.tx_half;
         if (!s_q.tx_half)
         begin
            s_d.txd = s_q.tx_shift[0];
         end
         else
         begin
            s_d.tx_shift = {1'b1, s_q.tx_shift[10:1]};
            s_d.tx_cnt = s_q.tx_cnt + 4'h1;
            if (s_q.tx_cnt == s_q.tx_len - 4'h1)
            begin
               s_d.tx_busy = 1'b0;
               s_d.status[STAT_TX_BIT] = 1'b1;
            end
         end
      end

      // ===================================================
      // uart receiver: samples at mid bit
      if (!io_mode && s_q.receive_enable && !s_q.rx_busy && rxd_fall)
      begin
         s_d.rx_busy = 1'b1;
         s_d.rx_cnt = 4'h0;
         s_d.rx_half = 1'b0;
      end
      if (s_q.rx_busy && rx_tick)
      begin
         s_d.rx_half = !s_q.rx_half;
         if (!s_q.rx_half)
         begin
            s_d.rx_shift = rx_new;
            s_d.rx_cnt = s_q.rx_cnt + 4'h1;
            // a start bit that is high again was a glitch
            if (s_q.rx_cnt == 4'h0 && sin)
            begin
               s_d.rx_busy = 1'b0;
            end
            else if (s_q.rx_cnt == rlen - 4'h1)
            begin
               s_d.rx_busy = 1'b0;
               s_d.ferr = !sin;
               if (s_q.mode == MODE_UART9)
               begin
                  s_d.rb8 = rext;
                  s_d.perr = 1'b0;
               end
               else
               begin
                  s_d.perr = s_q.pe && (rext != par_bit(rdat, s_q.even));
               end
               if (deliver)
               begin
                  s_d.rx_buf = rdat;
                  s_d.status[STAT_RX_BIT] = 1'b1;
               end
            end
         end
      end

      // mode change abandons any transfer in flight
      if (s_q.mode != s_d.mode)
      begin
         s_d.io_busy = 1'b0;
         s_d.tx_busy = 1'b0;
         s_d.rx_busy = 1'b0;
         s_d.sclk_out = 1'b1;
         s_d.txd = 1'b1;
      end
      if (!io_mode && !s_q.tx_busy)
      begin
         s_d.txd = s_d.tx_busy ? s_d.txd : 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s_q <= '0;
         s_q.sync_sclk <= 2'h3;
         s_q.sync_rxd <= 2'h3;
         s_q.sclk_prev <= 1'b1;
         s_q.rxd_prev <= 1'b1;
         s_q.mode <= MODE_IO;
         s_q.div <= DIV_RESET;
         s_q.mask <= MASK_RESET;
         s_q.sclk_out <= 1'b1;
         s_q.txd <= 1'b1;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // ======================================================
   // pins and interrupt
   // open drain only pulls low, letting several nodes share the line
   assign pins_out.serial_out_pin = s_q.odrain ? 1'b0 : s_q.txd;
   assign pins_out.serial_out_pin_oe = s_q.odrain ? !s_q.txd : 1'b1;
   assign pins_out.shift_clock_pin = s_q.sclk_out;
   assign pins_out.shift_clock_pin_oe = io_mode && !s_q.ext_clk;
   assign irq = |(s_q.status & s_q.mask);

endmodule // serial_channel

// [core/serial_channel_pkg.sv]
/*
 constants and carrier types of the serial channel: register offsets, field
 positions, reset values, operating modes, bus and pin structs.
 assumes an apb master with 32-bit data and byte addresses.
*/
// Operation
// - internal clock i/o: write sends eight bits
// - word finished sets transmit done flag
// - external clock i/o: shift on incoming clock
// - internal i/o receive starts after flag cleared
// - eight bits received: buffer, flag, interrupt
// - first shift clock starts with receive enable
// - external i/o receive waits for flag clear
// - transmit on falling, receive on rising edge
// - mode field selects 7, 8, 9 bit uart
// - optional even or odd parity, 7/8 bit
// - no parity in 9-bit mode
// - ninth bit from mode, into control register
// - wakeup: interrupt only when ninth bit set
package serial_channel_pkg;

   // ======================================================
   // register map
   localparam logic [7:0] BUF_OFS = 8'h00;
   localparam logic [7:0] MODE_OFS = 8'h04;
   localparam logic [7:0] CTRL_OFS = 8'h08;
   localparam logic [7:0] STAT_OFS = 8'h0c;
   localparam logic [7:0] MASK_OFS = 8'h10;
   localparam logic [7:0] DIV_OFS = 8'h14;

   // ======================================================
   // field positions
   localparam int MODE_SM_LO = 0;
   localparam int MODE_RXE_BIT = 2;
   localparam int MODE_WU_BIT = 3;
   localparam int MODE_TB8_BIT = 4;
   localparam int MODE_EXTCLK_BIT = 5;
   localparam int MODE_ODRAIN_BIT = 6;
   localparam int CTRL_PE_BIT = 0;
   localparam int CTRL_EVEN_BIT = 1;
   localparam int STAT_TX_BIT = 0;
   localparam int STAT_RX_BIT = 1;

   // ======================================================
   // reset values and timing
   // half a bit period in pclk cycles: 80 ns at 5 ns
   localparam logic [15:0] DIV_RESET = 16'h0010;
   localparam logic [1:0] MASK_RESET = 2'h0;
   localparam logic [3:0] IO_BITS = 4'h8;

   // ======================================================
   // modes
   typedef enum logic [1:0]
   {
      MODE_IO = 2'b00,
      MODE_UART7 = 2'b01,
      MODE_UART8 = 2'b10,
      MODE_UART9 = 2'b11
   } mode_type;

   // ======================================================
   // carriers
   typedef struct packed
   {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } apb_req_type;

   typedef struct packed
   {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } apb_rsp_type;

   typedef struct packed
   {
      logic serial_in_pin;
      logic shift_clock_pin;
   } pin_in_type;

   typedef struct packed
   {
      logic serial_out_pin;
      logic serial_out_pin_oe;
      logic shift_clock_pin;
      logic shift_clock_pin_oe;
   } pin_out_type;

endpackage

// [core/bit_timer.sv]
/*
 half-bit tick generator for the serial channel.
 assumes div is stable while a transfer runs; div of zero acts as one.
*/
`timescale 1ns/1ps
module bit_timer
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic restart,
   input wire logic [15:0] div,
   output logic tick
);
   typedef struct packed
   {
      logic [15:0] cnt;
   } timer_state_type;

   timer_state_type s_q;
   timer_state_type s_d;

   assign tick = !restart && (s_q.cnt + 16'h0001 >= div);

   always_comb
   begin
      s_d = s_q;
      if (restart || tick)
      begin
         s_d.cnt = 16'h0000;
      end
      else
      begin
         s_d.cnt = s_q.cnt + 16'h0001;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end
endmodule // bit_timer

// [dv/serial_channel_assertions.sv]
/*
 port checks of the serial channel, bound to its top module.
 assumes zero-wait apb and a mode/divider shadow rebuilt from bus writes.
*/
`timescale 1ns/1ps
module serial_channel_assertions
(
   input wire logic pclk,
   input wire logic presetn,
   input serial_channel_pkg::apb_req_type apb_req,
   input serial_channel_pkg::apb_rsp_type apb_rsp,
   input serial_channel_pkg::pin_in_type pins_in,
   input serial_channel_pkg::pin_out_type pins_out,
   input wire logic irq
);
   import serial_channel_pkg::*;
   // ==================================================
   // shadow state
   logic [6:0] mode_q, mode_d;
   logic [15:0] div_q, div_d;
   logic [16:0] low_q, low_d;
   logic wr, line, io_int, uart;
   assign wr = apb_req.psel && apb_req.penable && apb_req.pwrite && apb_rsp.pready;
   // open drain: a released line reads high
   assign line = pins_out.serial_out_pin_oe ? pins_out.serial_out_pin : 1'b1;
   assign io_int = mode_q[1:0] == MODE_IO && !mode_q[MODE_EXTCLK_BIT];
   assign uart = mode_q[1:0] != MODE_IO;
   always_comb
   begin
      mode_d = mode_q;
      div_d = div_q;
      if (wr && apb_req.paddr == MODE_OFS)
         mode_d = apb_req.pwdata[6:0];
      if (wr && apb_req.paddr == DIV_OFS)
         div_d = apb_req.pwdata[15:0];
      low_d = (line || !uart) ? 17'h0 : low_q + 17'h1;
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         mode_q <= 7'h0;
         div_q <= DIV_RESET;
         low_q <= 17'h0;
      end
      else
      begin
         mode_q <= mode_d;
         div_q <= div_d;
         low_q <= low_d;
      end
   end
   // ==================================================
   // properties
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_sclk_drive;
      pins_out.shift_clock_pin_oe == io_int;
   endproperty
   a_sclk_drive: assert property (p_sclk_drive) else $error("shift clock drive wrong");
   property p_open_drain;
      mode_q[MODE_ODRAIN_BIT] |-> !pins_out.serial_out_pin;
   endproperty
   a_open_drain: assert property (p_open_drain) else $error("open drain drives high");
   property p_tx_hold;
      io_int && $past(io_int) && pins_out.shift_clock_pin && $past(pins_out.shift_clock_pin) |-> $stable(line);
   endproperty
   a_tx_hold: assert property (p_tx_hold) else $error("data moved while clock high");
   property p_irq_rise;
      $rose(irq) && io_int |-> pins_out.shift_clock_pin;
   endproperty
   a_irq_rise: assert property (p_irq_rise) else $error("word ended on low clock");
   property p_bit_time;
      $rose(line) && uart && $past(uart) |-> (low_q % {div_q, 1'b0}) == 17'h0;
   endproperty
   a_bit_time: assert property (p_bit_time) else $error("bit time not whole");
   property p_irq_mask;
      wr && apb_req.paddr == MASK_OFS && apb_req.pwdata[1:0] == 2'b00 |=> !irq;
   endproperty
   a_irq_mask: assert property (p_irq_mask) else $error("masked irq high");
   property p_slverr;
      apb_req.psel && apb_req.penable && (apb_req.paddr > DIV_OFS || apb_req.paddr[1:0] != 2'b00)
         |-> apb_rsp.pslverr;
   endproperty
   a_slverr: assert property (p_slverr) else $error("unmapped without error");
   property p_rdata_idle;
      !(apb_req.psel && apb_req.penable && !apb_req.pwrite) |-> apb_rsp.prdata == 32'h0;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read");
   c_io_done: cover property (io_int && $rose(irq));
   c_uart_done: cover property (uart && $rose(irq));
   c_od_low: cover property (mode_q[MODE_ODRAIN_BIT] && $fell(line));
endmodule // serial_channel_assertions

bind serial_channel serial_channel_assertions u_chk
(
   .pclk(pclk),
   .presetn(presetn),
   .apb_req(apb_req),
   .apb_rsp(apb_rsp),
   .pins_in(pins_in),
   .pins_out(pins_out),
   .irq(irq)
);

// [dv/serial_peer.sv]
/*
 far side: external 8-bit shift register with its own shift clock source.
 assumes the channel idles the shift clock high and shifts lsb first.
*/
`timescale 1ns/1ps
module serial_peer
(
   input wire logic sclk_dut,
   input wire logic sclk_dut_oe,
   input wire logic txd_line,
   output logic rxd,
   output logic sclk_ext
);
   logic [7:0] sr;
   logic [7:0] cap;
   logic eff;
   assign eff = sclk_dut_oe ? sclk_dut : sclk_ext;
   initial
   begin
      rxd = 1'b1;
      sclk_ext = 1'b1;
      sr = 8'h00;
      cap = 8'h00;
   end
   // shift out on falling, capture on rising
   always @(negedge eff)
   begin
      rxd <= sr[0];
      sr <= {1'b1, sr[7:1]};
   end
   always @(posedge eff)
      cap <= {txd_line, cap[7:1]};
   task automatic load(input logic [7:0] b);
      sr = b;
   endtask
   // clock stands still high outside a word; odd offset keeps phase apart
   task automatic burst;
      #1.3;
      repeat (8)
      begin
         #80 sclk_ext = 1'b0;
         #80 sclk_ext = 1'b1;
      end
   endtask
endmodule // serial_peer

// [dv/serial_channel_tb_top.sv]
/*
 self-checking bench: registers, i/o mode both clock sources, uart frames.
 assumes the peer model and checker of this folder.
*/
`timescale 1ns/1ps
module serial_channel_tb_top;
   import serial_channel_pkg::*;
   localparam int DIV = 4;
   logic pclk, presetn, irq, loop_en, prx, pext, line;
   apb_req_type req;
   apb_rsp_type rsp;
   pin_in_type pin_i;
   pin_out_type pin_o;
   int fail_count, samples_checked;
   assign line = pin_o.serial_out_pin_oe ? pin_o.serial_out_pin : 1'b1;
   assign pin_i = {loop_en ? line : prx, pext};
   serial_channel u_dut(.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
      .pins_in(pin_i), .pins_out(pin_o), .irq(irq));
   serial_peer u_peer(.sclk_dut(pin_o.shift_clock_pin), .sclk_dut_oe(pin_o.shift_clock_pin_oe),
      .txd_line(line), .rxd(prx), .sclk_ext(pext));
   initial
   begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   // ==================================================
   // helpers
   task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         fail_count++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
      output logic e);
      @(posedge pclk);
      req <= '{1'b1, 1'b0, w, a, d};
      @(posedge pclk);
      req.penable <= 1'b1;
      // no wait-state count assumed: only the watchdog ends a stuck access
      do
      begin
         @(posedge pclk);
      end while (rsp.pready !== 1'b1);
      r = rsp.prdata;
      e = rsp.pslverr;
      req <= '0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      cmp(what, exp, r);
   endtask
   task automatic wirq;
      for (int n = 0; n < 2000 && irq !== 1'b1; n++)
         @(posedge pclk);
      cmp("irq raised", 1, irq);
   endtask
   task automatic irq_is(input logic exp);
      #1;
      cmp("irq level", exp, irq);
   endtask
   task automatic sclk_low(input int n, input logic exp);
      logic seen;
      seen = 1'b0;
      repeat (n)
      begin
         @(posedge pclk);
         seen |= (pin_o.shift_clock_pin === 1'b0);
      end
      cmp("shift clock low", exp, seen);
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // ==================================================
   // scenarios
   task automatic t_regs;
      logic [31:0] r;
      logic e;
      rchk(MODE_OFS, 32'h0, "mode");
      rchk(CTRL_OFS, 32'h0, "ctrl");
      rchk(STAT_OFS, 32'h0, "status");
      rchk(MASK_OFS, 32'h0, "mask");
      rchk(DIV_OFS, 32'h10, "div");
      apb(1'b0, 8'h18, 32'h0, r, e);
      cmp("unmapped", 32'h1, {r[30:0], e});
      wr(DIV_OFS, DIV);
      wr(MASK_OFS, 32'h3);
   endtask
   task automatic t_io_rx;
      u_peer.load(8'ha5);
      wr(MODE_OFS, 32'h4);
      sclk_low(4 * DIV, 1);
      wirq();
      rchk(STAT_OFS, 32'h2, "rx status");
      sclk_low(40, 0);
      u_peer.load(8'h3c);
      rchk(BUF_OFS, 32'ha5, "rx byte");
      sclk_low(4 * DIV, 1);
      wirq();
      // drop receive enable first, or reading the byte re-arms the receiver
      wr(MODE_OFS, 32'h0);
      rchk(BUF_OFS, 32'h3c, "rx byte");
   endtask
   task automatic t_io_tx;
      wr(STAT_OFS, 32'h3);
      wr(BUF_OFS, 32'h3c);
      wirq();
      cmp("shifted out", 32'h3c, u_peer.cap);
      rchk(STAT_OFS, 32'h1, "tx status");
      wr(MASK_OFS, 32'h2);
      irq_is(1'b0);
      wr(MASK_OFS, 32'h3);
      irq_is(1'b1);
      wr(STAT_OFS, 32'h1);
      irq_is(1'b0);
   endtask
   // a word's direction is fixed at its start: the transmit word goes first,
   // the receive word armed meanwhile follows on the next burst
   task automatic t_io_ext;
      wr(MODE_OFS, 32'h20);
      wr(BUF_OFS, 32'h96);
      wr(MODE_OFS, 32'h24);
      u_peer.burst();
      wirq();
      cmp("ext shifted out", 32'h96, u_peer.cap);
      u_peer.load(8'h5a);
      u_peer.burst();
      repeat (8) @(posedge pclk);
      rchk(STAT_OFS, 32'h3, "duplex status");
      rchk(BUF_OFS, 32'h5a, "ext rx byte");
   endtask
   task automatic uc(input logic [6:0] md, input logic [1:0] cr, input logic [7:0] b, input logic ok);
      logic [11:0] f, g;
      int w, n;
      logic p;
      w = (md[1:0] == 2'b01) ? 7 : 8;
      f = 12'h0;
      g = 12'h0;
      p = 1'b0;
      for (int i = 0; i < w; i++)
      begin
         f[i + 1] = b[i];
         p ^= b[i];
      end
      n = w + 1;
      if (md[1:0] == 2'b11 || cr[0])
      begin
         f[n] = (md[1:0] == 2'b11) ? md[4] : ~(p ^ cr[1]);
         n++;
      end
      f[n] = 1'b1;
      n++;
      wr(MODE_OFS, {25'h0, md});
      wr(CTRL_OFS, {30'h0, cr});
      wr(STAT_OFS, 32'h3);
      wr(BUF_OFS, {24'h0, b});
      for (int i = 0; i < 200 && line !== 1'b0; i++)
         @(posedge pclk);
      repeat (DIV) @(posedge pclk);
      for (int i = 0; i < n; i++)
      begin
         g[i] = line;
         repeat (2 * DIV) @(posedge pclk);
      end
      cmp("frame", f, g);
      repeat (2 * DIV) @(posedge pclk);
      rchk(STAT_OFS, {30'h0, ok, 1'b1}, "status");
      if (ok)
      begin
         rchk(CTRL_OFS, {29'h0, md[1:0] == 2'b11 && md[4], cr}, "control");
         rchk(BUF_OFS, w == 7 ? {25'h0, b[6:0]} : {24'h0, b}, "rx byte");
      end
   endtask
   initial
   begin
      presetn = 1'b0;
      req = '0;
      loop_en = 1'b0;
      fail_count = 0;
      samples_checked = 0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_io_rx();
      t_io_tx();
      t_io_ext();
      @(posedge pclk);
      loop_en <= 1'b1;
      uc(7'h05, 2'b00, 8'h35, 1'b1);
      uc(7'h05, 2'b11, 8'h5b, 1'b1);
      uc(7'h06, 2'b01, 8'hc3, 1'b1);
      uc(7'h06, 2'b00, 8'h81, 1'b1);
      uc(7'h17, 2'b11, 8'h6e, 1'b1);
      uc(7'h4f, 2'b00, 8'h12, 1'b0);
      uc(7'h5f, 2'b00, 8'ha7, 1'b1);
      tally_and_finish();
   end
   initial
   begin
      repeat (40000) @(posedge pclk);
      fail_count++;
      tally_and_finish();
   end
endmodule // serial_channel_tb_top
